// >>> core/dis_top.sv
// drive interface status and handshake logic facing the controller
// ------------------------------------------------------------
// Overview of operation
// [R1] controller write pulses 100 to 150 ns
// [R2] ready stays low .125-.150 s after Load
// [R3] leaving-run flag rises at once on Load
// [R4] leaving-run flag rises on mains power loss
// [R5] controller may hold off on leaving-run flag
// [R6] address acknowledge pulse low for 1 us
// [R7] seek incomplete held until restore or reload
// [R8] write check fault on missing write current
// [R9] write protect pulse ignores unit select
// [R10] compat index, interlock, acknowledge pulse timings
// ------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module dis_top
	import dis_pkg::*;
#(
	parameter int READY_HOLD = dis_pkg::READY_HOLD_CYC
)
(
	input  wire logic                 CLOCK_IN,
	input  wire logic                 RST_IN,
	input  wire logic                 CE_IN,
	input  wire logic                 RUN_SWITCH_IN,
	input  wire logic                 MAINS_POWER_GOOD_IN,
	input  wire logic                 DRIVE_OK_IN,
	input  wire logic                 ADDR_ACCEPT_IN,
	input  wire logic                 STROBE_IN,
	input  wire logic                 RESTORE_IN,
	input  wire logic                 SEEK_FAIL_IN,
	input  wire logic                 WRITE_GATE_N_IN,
	input  wire dis_pkg::dis_wcur_t   WRITE_CURRENT_IN,
	input  wire logic                 WRITE_PROTECT_PULSE_IN,
	input  wire logic                 INDEX_MARK_IN,
	input  wire logic                 INTERLOCK_LEVEL_IN,
	input  wire dis_pkg::dis_compat_t COMPAT_IN,
	output logic                      FILE_READY_N_OUT,
	output logic                      LEAVING_RUN_OUT,
	output logic                      SEEK_TARGET_ACCEPT_SIGNAL_N_OUT,
	output logic                      ADDRESS_INTERLOCK_SIGNAL_OUT,
	output logic                      SEEK_INCOMPLETE_OUT,
	output logic                      WRITE_CHECK_OUT,
	output logic                      WRITE_PROTECT_OUT,
	output logic                      INDEX_OUT
);
	import dis_pkg::*;

	dis_mode_t  mode;
	dis_mode_t  next_mode;
	logic [CNT_W-1:0] hold_cnt;
	logic [CNT_W-1:0] next_hold_cnt;
	logic       next_ready_n;
	logic       next_leaving;
	logic       seek_inc;
	logic       next_seek_inc;
	logic       wprot;
	logic       run_q;
	logic       idx_q;
	logic [CNT_W-1:0] idx_cnt;
	logic [CNT_W-1:0] next_idx_cnt;
	logic       std_ack_trig;
	logic       cmp_trig;
	logic       ack_std;
	logic       ack_cmp;
	logic       lai_cmp;

	// ------------------------------------------------------------
	// run/load mode and ready timing
	// ------------------------------------------------------------
	// ready low is held through the leaving phase so transfers can finish
	always_comb
	begin
		next_mode     = mode;
		next_hold_cnt = hold_cnt;
		unique case (mode)
			DIS_LOAD:
				if (RUN_SWITCH_IN && MAINS_POWER_GOOD_IN)
					next_mode = DIS_RUN;
			DIS_RUN:
				if (!RUN_SWITCH_IN || !MAINS_POWER_GOOD_IN)
				begin
					next_mode     = DIS_LEAVING;
					next_hold_cnt = CNT_W'(READY_HOLD);
				end
			DIS_LEAVING:
				if (hold_cnt <= 1)
					next_mode = DIS_LOAD; // [R2]
				else
					next_hold_cnt = hold_cnt - 1'b1;
		endcase
		// ready only in run, or while draining from run
		next_ready_n = !((next_mode != DIS_LOAD) && DRIVE_OK_IN); // [R2]
		// immediate on mode change or power loss
		next_leaving = (next_mode != DIS_RUN) || !MAINS_POWER_GOOD_IN; // [R3] [R4]
	end

	always_ff @(posedge CLOCK_IN)
	begin
		if (RST_IN)
		begin
			mode             <= DIS_LOAD;
			hold_cnt         <= '0;
			FILE_READY_N_OUT <= 1'b1;
			LEAVING_RUN_OUT  <= 1'b1;
		end
		else if (CE_IN)
		begin
			mode             <= next_mode;
			hold_cnt         <= next_hold_cnt;
			FILE_READY_N_OUT <= next_ready_n;
			LEAVING_RUN_OUT  <= next_leaving;
		end
	end

	// ------------------------------------------------------------
	// seek incomplete, write check, write protect
	// ------------------------------------------------------------
	// set wins over clear so a failure in the clearing cycle is kept
	always_comb
	begin
		next_seek_inc = seek_inc;
		if ((STROBE_IN && RESTORE_IN) || (mode == DIS_LOAD))
			next_seek_inc = 1'b0; // [R7]
		if (SEEK_FAIL_IN)
			next_seek_inc = 1'b1;
	end

	always_ff @(posedge CLOCK_IN)
	begin
		if (RST_IN)
		begin
			seek_inc            <= 1'b0;
			SEEK_INCOMPLETE_OUT <= 1'b0;
			WRITE_CHECK_OUT     <= 1'b0;
			wprot               <= 1'b0;
			WRITE_PROTECT_OUT   <= 1'b0;
		end
		else if (CE_IN)
		begin
			seek_inc            <= next_seek_inc;
			SEEK_INCOMPLETE_OUT <= next_seek_inc; // [R7]
			// either current missing while gate active
			WRITE_CHECK_OUT     <= !WRITE_GATE_N_IN &&
				(!WRITE_CURRENT_IN.dc_current || !WRITE_CURRENT_IN.ac_current); // [R8]
			// no unit select term: every chained drive sees the pulse
			wprot               <= wprot || WRITE_PROTECT_PULSE_IN; // [R9]
			WRITE_PROTECT_OUT   <= wprot || WRITE_PROTECT_PULSE_IN;
		end
	end

	// ------------------------------------------------------------
	// acknowledge and interlock pulses
	// ------------------------------------------------------------
	assign std_ack_trig = ADDR_ACCEPT_IN && !COMPAT_IN.ack_pulse;
	assign cmp_trig     = STROBE_IN && !run_q;

	dis_pulse u_ack_std
	(
		.clk_in    (CLOCK_IN),
		.rst_in    (RST_IN),
		.ce_in     (CE_IN),
		.trig_in   (std_ack_trig),
		.delay_in  ('0),
		.width_in  (CNT_W'(ACK_STD_CYC)),
		.pulse_out (ack_std)
	); // [R6]

	dis_pulse u_ack_cmp
	(
		.clk_in    (CLOCK_IN),
		.rst_in    (RST_IN),
		.ce_in     (CE_IN),
		.trig_in   (cmp_trig && COMPAT_IN.ack_pulse),
		.delay_in  (CNT_W'(COMPAT_DELAY_CYC)),
		.width_in  (CNT_W'(COMPAT_PULSE_CYC)),
		.pulse_out (ack_cmp)
	); // [R10]

	dis_pulse u_lai_cmp
	(
		.clk_in    (CLOCK_IN),
		.rst_in    (RST_IN),
		.ce_in     (CE_IN),
		.trig_in   (cmp_trig && COMPAT_IN.interlock_pulse),
		.delay_in  (CNT_W'(COMPAT_DELAY_CYC)),
		.width_in  (CNT_W'(COMPAT_PULSE_CYC)),
		.pulse_out (lai_cmp)
	); // [R10]

	// index mark stretched to 40us or 5us from its rising edge
	always_comb
	begin
		next_idx_cnt = (idx_cnt != '0) ? idx_cnt - 1'b1 : '0;
		if (INDEX_MARK_IN && !idx_q)
			next_idx_cnt = COMPAT_IN.index_short ? CNT_W'(INDEX_CMP_CYC)
				: CNT_W'(INDEX_STD_CYC); // [R10]
	end

	always_ff @(posedge CLOCK_IN)
	begin
		if (RST_IN)
		begin
			run_q                           <= 1'b0;
			idx_q                           <= 1'b0;
			idx_cnt                         <= '0;
			INDEX_OUT                       <= 1'b0;
			SEEK_TARGET_ACCEPT_SIGNAL_N_OUT <= 1'b1;
			ADDRESS_INTERLOCK_SIGNAL_OUT    <= 1'b0;
		end
		else if (CE_IN)
		begin
			run_q                           <= STROBE_IN;
			idx_q                           <= INDEX_MARK_IN;
			idx_cnt                         <= next_idx_cnt;
			INDEX_OUT                       <= next_idx_cnt != '0;
			SEEK_TARGET_ACCEPT_SIGNAL_N_OUT <= !(ack_std || ack_cmp); // [R6] [R10]
			ADDRESS_INTERLOCK_SIGNAL_OUT    <= COMPAT_IN.interlock_pulse ? lai_cmp
				: INTERLOCK_LEVEL_IN;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	AST_LEAVE_IMMEDIATE: assert property (@(posedge CLOCK_IN) disable iff (RST_IN) // [R3]
		(CE_IN && mode == DIS_RUN && !RUN_SWITCH_IN) |=> LEAVING_RUN_OUT)
		else $error("leaving run not raised at once");
	AST_POWER_LOSS: assert property (@(posedge CLOCK_IN) disable iff (RST_IN) // [R4]
		(CE_IN && !MAINS_POWER_GOOD_IN) |=> LEAVING_RUN_OUT)
		else $error("leaving run not raised on power loss");
	AST_READY_HOLD: assert property (@(posedge CLOCK_IN) disable iff (RST_IN) // [R2]
		(CE_IN && mode == DIS_RUN && next_mode == DIS_LEAVING && DRIVE_OK_IN)
		|=> (mode == DIS_LEAVING) && !FILE_READY_N_OUT)
		else $error("ready dropped at run to load");
	AST_SEEK_HOLD: assert property (@(posedge CLOCK_IN) disable iff (RST_IN) // [R7]
		(CE_IN && seek_inc && !(STROBE_IN && RESTORE_IN) && mode != DIS_LOAD)
		|=> seek_inc)
		else $error("seek incomplete lost");
	AST_WCHECK: assert property (@(posedge CLOCK_IN) disable iff (RST_IN) // [R8]
		(CE_IN && !WRITE_GATE_N_IN && !WRITE_CURRENT_IN.ac_current) |=> WRITE_CHECK_OUT)
		else $error("write check missed");
	AST_WPROT: assert property (@(posedge CLOCK_IN) disable iff (RST_IN) // [R9]
		(CE_IN && WRITE_PROTECT_PULSE_IN) |=> WRITE_PROTECT_OUT)
		else $error("write protect pulse ignored");
	AST_ACK_WIDTH: assert property (@(posedge CLOCK_IN) disable iff (RST_IN || !CE_IN) // [R6]
		$rose(ack_std) |-> ack_std [*8])
		else $error("acknowledge pulse too short");
	AST_CMP_DELAY: assert property (@(posedge CLOCK_IN) disable iff (RST_IN || !CE_IN) // [R10]
		(cmp_trig && COMPAT_IN.ack_pulse) |=> !ack_cmp [*8])
		else $error("compat acknowledge too early");
endmodule
`default_nettype wire

// >>> core/dis_pkg.sv
// shared constants and carrier types for the drive interface status block
package dis_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ          = 200;
	localparam int READY_HOLD_MIN_MS_X1000 = 125; // .125 s in microseconds/1000
	localparam int READY_HOLD_MAX_MS_X1000 = 150; // .150 s
	// ready hold picked midway in the window, in microseconds
	localparam int READY_HOLD_US    = (READY_HOLD_MIN_MS_X1000 + READY_HOLD_MAX_MS_X1000) * 500;
	localparam int READY_HOLD_CYC   = READY_HOLD_US * CLK_MHZ;
	localparam int ACK_STD_NS       = 1000;       // 1 microsecond low
	localparam int ACK_STD_CYC      = ACK_STD_NS * CLK_MHZ / 1000;
	localparam int COMPAT_PULSE_US  = 5;
	localparam int COMPAT_PULSE_CYC = COMPAT_PULSE_US * CLK_MHZ;
	localparam int COMPAT_DELAY_US  = 30;
	localparam int COMPAT_DELAY_CYC = COMPAT_DELAY_US * CLK_MHZ;
	localparam int INDEX_STD_US     = 40;
	localparam int INDEX_STD_CYC    = INDEX_STD_US * CLK_MHZ;
	localparam int INDEX_CMP_CYC    = COMPAT_PULSE_CYC;
	localparam int CNT_W            = 26;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic index_short;     // 5us index mark instead of 40us
		logic interlock_pulse; // interlock as delayed pulse
		logic ack_pulse;       // acknowledge as delayed pulse
	} dis_compat_t;

	typedef struct packed {
		logic dc_current;
		logic ac_current;
	} dis_wcur_t;

	typedef enum logic [1:0] {
		DIS_LOAD    = 2'b00,
		DIS_RUN     = 2'b01,
		DIS_LEAVING = 2'b11
	} dis_mode_t;
endpackage

// >>> core/dis_pulse.sv
// delayed pulse generator: waits a delay after a trigger then emits a pulse
`timescale 1ns/10ps
`default_nettype none
module dis_pulse
	import dis_pkg::*;
#(
	parameter int CNT_WIDTH = dis_pkg::CNT_W
)
(
	input  wire logic                 clk_in,
	input  wire logic                 rst_in,
	input  wire logic                 ce_in,
	input  wire logic                 trig_in,
	input  wire logic [CNT_WIDTH-1:0] delay_in,
	input  wire logic [CNT_WIDTH-1:0] width_in,
	output var  logic                 pulse_out
);
	logic [CNT_WIDTH-1:0] cnt;
	logic                 waiting;
	logic [CNT_WIDTH-1:0] next_cnt;
	logic                 next_waiting;
	logic                 next_pulse;

	// ------------------------------------------------------------
	// delay then width; a new trigger restarts the sequence
	// ------------------------------------------------------------
	always_comb
	begin
		next_cnt     = cnt;
		next_waiting = waiting;
		next_pulse   = pulse_out;
		if (trig_in)
		begin
			if (delay_in == '0)
			begin
				next_waiting = 1'b0;
				next_pulse   = 1'b1;
				next_cnt     = width_in;
			end
			else
			begin
				next_waiting = 1'b1;
				next_pulse   = 1'b0;
				next_cnt     = delay_in;
			end
		end
		else if (cnt > 1)
			next_cnt = cnt - 1'b1;
		else if (waiting)
		begin
			next_waiting = 1'b0;
			next_pulse   = 1'b1;
			next_cnt     = width_in;
		end
		else
		begin
			next_pulse = 1'b0;
			next_cnt   = '0;
		end
	end

	// registers only
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			cnt       <= '0;
			waiting   <= 1'b0;
			pulse_out <= 1'b0;
		end
		else if (ce_in)
		begin
			cnt       <= next_cnt;
			waiting   <= next_waiting;
			pulse_out <= next_pulse;
		end
	end
endmodule
`default_nettype wire

// >>> bench/dis_ctrl_model.sv
// controller model that issues strobe and restore commands
`timescale 1ns/10ps
`default_nettype none
module dis_ctrl_model
(
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic go_in,
	input  wire logic restore_in,
	input  wire logic write_in,
	input  wire logic leaving_run_in,
	output logic      strobe_out,
	output logic      restore_out,
	output logic      wdata_out
);
	// write data pulse length in 5 ns cycles, inside the 100 to 150 ns window
	localparam int WR_PULSE_CYC = 24;
	int            wr_cnt;

	// one-cycle strobe per request; held off while the drive leaves run
	// one process drives every output so reset and requests never race
	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			strobe_out  <= 1'b0;
			restore_out <= 1'b0;
			wdata_out   <= 1'b0;
			wr_cnt      <= 0;
		end
		else
		begin
			strobe_out  <= go_in && !leaving_run_in && !strobe_out;
			restore_out <= go_in && restore_in;
			// one bounded write data pulse per request
			if (write_in && wr_cnt == 0)
				wr_cnt <= WR_PULSE_CYC;
			else if (wr_cnt != 0)
				wr_cnt <= wr_cnt - 1;
			wdata_out   <= (write_in && wr_cnt == 0) || wr_cnt > 1;
		end
	end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the drive interface status block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import dis_pkg::*;
	// ----
	// signals
	// ----
	localparam int HOLD = 50; // short ready hold keeps the run brief
	logic        clk, rst, run_sw, pwr, acc, sfail, wg_n, wp, idx, ilk, go, rq;
	dis_wcur_t   wcur;
	dis_compat_t cmp;
	logic        rdy_n, lv, ack_n, ai, si, wc, wpo, ix, stb, rs;
	logic        ce, dok, wr, wd;
	int          miscompares, n_checks, n;
	// device under test
	dis_top #(.READY_HOLD(HOLD)) i_dut
	(
		.CLOCK_IN(clk),
		.RST_IN(rst),
		.CE_IN(ce),
		.RUN_SWITCH_IN(run_sw),
		.MAINS_POWER_GOOD_IN(pwr),
		.DRIVE_OK_IN(dok),
		.ADDR_ACCEPT_IN(acc),
		.STROBE_IN(stb),
		.RESTORE_IN(rs),
		.SEEK_FAIL_IN(sfail),
		.WRITE_GATE_N_IN(wg_n),
		.WRITE_CURRENT_IN(wcur),
		.WRITE_PROTECT_PULSE_IN(wp),
		.INDEX_MARK_IN(idx),
		.INTERLOCK_LEVEL_IN(ilk),
		.COMPAT_IN(cmp),
		.FILE_READY_N_OUT(rdy_n),
		.LEAVING_RUN_OUT(lv),
		.SEEK_TARGET_ACCEPT_SIGNAL_N_OUT(ack_n),
		.ADDRESS_INTERLOCK_SIGNAL_OUT(ai),
		.SEEK_INCOMPLETE_OUT(si),
		.WRITE_CHECK_OUT(wc),
		.WRITE_PROTECT_OUT(wpo),
		.INDEX_OUT(ix)
	);
	// controller on the far side
	dis_ctrl_model i_ctrl
	(
		.clk_in(clk),
		.rst_in(rst),
		.go_in(go),
		.restore_in(rq),
		.write_in(wr),
		.leaving_run_in(lv),
		.strobe_out(stb),
		.restore_out(rs),
		.wdata_out(wd)
	);
	// 200 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ----
	// helpers
	// ----
	function automatic logic get(int s);
		case (s)
			0: return rdy_n;
			1: return lv;
			2: return ack_n;
			3: return ai;
			4: return si;
			5: return wc;
			6: return wpo;
			7: return ix;
			default: return wd;
		endcase
	endfunction
	task automatic chk(logic g, logic e);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// cycle counts against an allowed window
	task automatic chk_n(int g, int lo, int hi);
		n_checks++;
		if (g < lo || g > hi)
		begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
		end
	endtask
	// bounded wait; n ends as the cycles waited, a hang closes the run
	task automatic wt(int s, logic v, int m);
		n = 0;
		while (get(s) !== v)
		begin
			@(negedge clk);
			n++;
			if (n > m)
			begin
				miscompares++;
				close_out();
			end
		end
	endtask
	task automatic pl(ref logic s);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic run_up();
		run_sw = 1'b1;
		pwr = 1'b1;
		wt(1, 1'b0, 10);
		wt(0, 1'b0, 10);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_wck();
		for (int i = 0; i < 8; i++)
		begin
			{wg_n, wcur} = 3'(i);
			@(negedge clk);
			@(negedge clk);
			chk(wc, !wg_n && !(wcur.dc_current && wcur.ac_current));
		end
		wg_n = 1'b1;
		// far-side write data pulse width
		pl(wr);
		wt(8, 1'b1, 4);
		wt(8, 1'b0, 40);
		chk_n(n, 20, 30);
	endtask
	// protect pulse taken in load mode, nothing selects the drive
	task automatic t_wp();
		chk(wpo, 1'b0);
		pl(wp);
		wt(6, 1'b1, 3);
		repeat (20) @(negedge clk);
		chk(wpo, 1'b1);
	endtask
	task automatic t_seek();
		pl(sfail);
		wt(4, 1'b1, 3);
		pl(go);
		repeat (10) @(negedge clk);
		chk(si, 1'b1);
		rq = 1'b1;
		pl(go);
		repeat (3) @(negedge clk);
		chk(si, 1'b0);
		rq = 1'b0;
		pl(sfail);
		wt(4, 1'b1, 3);
		run_sw = 1'b0;
		wt(1, 1'b1, 3);
		// the flag clears only once the drive has drained into Load
		wt(0, 1'b1, HOLD + 10);
		run_up();
		chk(si, 1'b0);
	endtask
	// pulse-mode ack then interlock, each from its own strobe
	task automatic t_cmp();
		cmp = 3'b111;
		pl(idx);
		wt(7, 1'b1, 4);
		wt(7, 1'b0, 9000);
		chk_n(n, INDEX_CMP_CYC, INDEX_CMP_CYC);
		for (int s = 2; s < 4; s++)
		begin
			pl(go);
			wt(s, s[0], 6100);
			chk_n(n, COMPAT_DELAY_CYC - 8, COMPAT_DELAY_CYC + 8);
			wt(s, !s[0], 1100);
			chk_n(n, COMPAT_PULSE_CYC, COMPAT_PULSE_CYC);
		end
		cmp = 3'b000;
		pl(idx);
		wt(7, 1'b1, 4);
		wt(7, 1'b0, 9000);
		chk_n(n, INDEX_STD_CYC, INDEX_STD_CYC);
		ilk = 1'b1;
		wt(3, 1'b1, 3);
		ilk = 1'b0;
		wt(3, 1'b0, 3);
	endtask
	// acknowledge pulse; nothing moves while the clock enable is low
	task automatic t_ack();
		ce = 1'b0;
		pl(acc);
		repeat (5) @(negedge clk);
		chk(ack_n, 1'b1);
		ce = 1'b1;
		pl(acc);
		wt(2, 1'b0, 4);
		wt(2, 1'b1, 300);
		chk_n(n, ACK_STD_CYC, ACK_STD_CYC);
	endtask
	// ready follows drive-ok, then drains for HOLD cycles after Run to Load
	task automatic t_leave();
		dok = 1'b0;
		@(negedge clk);
		@(negedge clk);
		chk(rdy_n, 1'b1);
		dok = 1'b1;
		wt(0, 1'b0, 3);
		run_sw = 1'b0;
		@(negedge clk);
		@(negedge clk);
		chk(lv, 1'b1);
		chk(rdy_n, 1'b0);
		// low from the switch edge for HOLD cycles; the wait starts one edge late
		wt(0, 1'b1, HOLD + 10);
		chk_n(n, HOLD - 1, HOLD - 1);
		run_up();
		pwr = 1'b0;
		@(negedge clk);
		@(negedge clk);
		chk(lv, 1'b1);
	endtask
	// ----
	// main sequence
	// ----
	initial
	begin
		{rst, run_sw, pwr, acc, sfail, wp, idx, ilk, go, rq} = 10'h200;
		ce = 1'b1;
		dok = 1'b1;
		wr = 1'b0;
		wg_n = 1'b1;
		wcur = 2'h3;
		cmp = 3'h0;
		miscompares = 0;
		n_checks = 0;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk(rdy_n, 1'b1);
		chk(lv, 1'b1);
		chk(ack_n, 1'b1);
		chk(si, 1'b0);
		t_wck();
		t_wp();
		run_up();
		t_ack();
		t_seek();
		t_cmp();
		t_leave();
		close_out();
	end
endmodule
`default_nettype wire
